/* rtl/adc_seq_map.vh */
// register offsets, field positions, reset values and timing for the readout sequencer
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

`define OFS_CONFIG        8'h00
`define OFS_SETUP         8'h04
`define OFS_STATUS        8'h08

`define CFG_SGL_BIT       0
`define CFG_CS_LSB        1
`define CFG_SCAN_LSB      5
`define CFG_RESET         8'h01

`define SETUP_CLK_BIT     3
`define SETUP_REFPIN_BIT  5
`define SETUP_RESET       8'h00

`define SCAN_UP_FROM_ZERO 2'h0
`define SCAN_REPEAT_EIGHT 2'h1
`define SCAN_UPPER_PART   2'h2
`define SCAN_SINGLE       2'h3

`define REPEAT_COUNT      4'h8
`define HIGHEST_CODE      4'hb
`define T_STRETCH_NS      7600
`define CLK_FREQ_MHZ      125
`define STRETCH_MARGIN    4

`endif

/* rtl/result_mem.v */
// small result memory with registered read data
`timescale 1ns/1ps
module result_mem #(
  parameter WIDTH = 10,
  parameter DEPTH = 12,
  parameter AW    = 4
) (
  input  wire             ref_clk_i,
  input  wire             wr_en_i,
  input  wire [AW-1:0]    wr_addr_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire [AW-1:0]    rd_addr_i,
  output reg  [WIDTH-1:0] rd_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

  always @(posedge ref_clk_i) begin
    if (wr_en_i)
      mem_reg[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem_reg[rd_addr_i];
  end
endmodule // result_mem

/* rtl/adc_i2c_readout_sequencer.v */
// conversion sequencer and i2c result readout with ahb-lite configuration registers
// Behaviour
// - differential codes pick adjacent pairs; odd code swaps polarity; above 1011 reserved
// - four-input variant zeroes two top select bits, eight-input zeroes top bit
// - shared pin as reference: its pair reads other input against ground
// - differential scan steps channel index by two up to the limit
// - matching address byte is acknowledged before any result data
// - result is two bytes msb first, six high bits then ten data bits
// - master ack continues, not-ack makes device release the data line
// - setup clock-source bit selects conversion clock, zero after reset
// - internal clock mode converts from own clock, not serial clock
// - internal mode tracking starts on eighth rising edge after valid address
// - internal mode samples and converts on ninth falling serial edge
// - serial clock held low until the whole scan has converted
// - multiple conversions run back to back into successive memory slots
// - memory holds one ten-bit entry per input
// - serial clock released once all conversions are stored
// - readout in conversion order at serial rates up to 1.7 mhz
// - clock held low no longer than 7.6 us per conversion
// - results come back first-in-first-out
// - shared pin used as reference is skipped by single-ended scans 00 and 10
// - reading past the last result wraps to the first
// - reads return stored results; new conversions need a new read address
// - clock-source bit set takes conversion clock from serial clock
// - single/differential bit: one single-ended, zero differential
// - scan 00 up to selected, 01 selected eight times, 11 selected once
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_i2c_readout_sequencer #(
  parameter       NUM_INPUTS = 12,
  parameter [6:0] SLAVE_ADDR = 7'h2a  // arbitrary value
) (
  input  wire        ref_clk_i,
  input  wire        sys_rst_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe_o,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  output reg         track_o,
  output reg         conv_start_o,
  output reg  [3:0]  conv_pos_o,
  output reg  [3:0]  conv_neg_o,
  output reg         conv_pos_gnd_o,
  output reg         conv_neg_gnd_o,
  output reg         conv_chan_invalid_o,
  output wire        conv_clk_ext_o,
  input  wire        conv_done_i,
  input  wire [9:0]  conv_data_i
);
  localparam integer TOP_INT     = NUM_INPUTS - 1;
  localparam integer STRETCH_CYC = (`T_STRETCH_NS * `CLK_FREQ_MHZ) / 1000;
  localparam integer LIMIT_INT   = STRETCH_CYC - `STRETCH_MARGIN;
  localparam [3:0] REF_CH      = TOP_INT[3:0];
  localparam       HAS_SHARED  = (NUM_INPUTS != 8);
  localparam [3:0] UPPER_START = (NUM_INPUTS == 4) ? 4'h2 : 4'h6;
  localparam [3:0] DEPTH_LAST  = TOP_INT[3:0];
  localparam [9:0] CONV_LIMIT  = LIMIT_INT[9:0];

  localparam [2:0] L_IDLE = 3'h0;
  localparam [2:0] L_ADDR = 3'h1;
  localparam [2:0] L_ACK  = 3'h2;
  localparam [2:0] L_TX   = 3'h3;
  localparam [2:0] L_MACK = 3'h4;
  localparam [2:0] L_WAIT = 3'h5;

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_REQ  = 2'h1;
  localparam [1:0] S_CONV = 2'h2;

  // ahb-lite slave
  reg  [7:0] cfg_reg;
  reg  [7:0] setup_reg;
  reg        wr_pend_reg;
  reg  [7:0] wr_addr_reg;
  reg  [31:0] status_word;

  wire ahb_go = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  wire [1:0] scan_mode = cfg_reg[`CFG_SCAN_LSB+1:`CFG_SCAN_LSB];
  wire [3:0] cs_raw    = cfg_reg[`CFG_CS_LSB+3:`CFG_CS_LSB];
  wire       sgl_sel   = cfg_reg[`CFG_SGL_BIT];
  wire       clk_ext   = setup_reg[`SETUP_CLK_BIT];
  wire       ref_mode  = setup_reg[`SETUP_REFPIN_BIT] & HAS_SHARED;

  assign conv_clk_ext_o = clk_ext;

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_reg     <= `CFG_RESET;
      setup_reg   <= `SETUP_RESET;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ahb_go & hwrite_i;
      if (ahb_go)
        wr_addr_reg <= haddr_i[7:0];
      if (wr_pend_reg) begin
        if (wr_addr_reg == `OFS_CONFIG)
          cfg_reg <= hwdata_i[7:0];
        else if (wr_addr_reg == `OFS_SETUP)
          setup_reg <= hwdata_i[7:0];
      end
      if (ahb_go & ~hwrite_i) begin
        if (haddr_i[7:0] == `OFS_CONFIG)
          hrdata_o <= {24'h000000, cfg_reg};
        else if (haddr_i[7:0] == `OFS_SETUP)
          hrdata_o <= {24'h000000, setup_reg};
        else if (haddr_i[7:0] == `OFS_STATUS)
          hrdata_o <= status_word;
        else
          hrdata_o <= 32'h0000_0000;
      end
    end
  end

  // pin synchronisers
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;

  // effective channel select per variant
  reg [3:0] cs_eff;
  always @* begin
    if (NUM_INPUTS == 4)
      cs_eff = {2'b00, cs_raw[1:0]};
    else if (NUM_INPUTS == 8)
      cs_eff = {1'b0, cs_raw[2:0]};
    else
      cs_eff = cs_raw;
  end

  // scan plan
  reg [3:0] top_ch, plan_first, plan_last, plan_step, plan_reps;
  always @* begin
    top_ch = (cs_eff > `HIGHEST_CODE) ? `HIGHEST_CODE : cs_eff;
    if (sgl_sel && ref_mode && top_ch == REF_CH)
      top_ch = REF_CH - 4'h1;
    if (!sgl_sel)
      top_ch = {top_ch[3:1], 1'b0};
    plan_step = sgl_sel ? 4'h1 : 4'h2;
    plan_reps = 4'h1;
    plan_first = 4'h0;
    plan_last  = top_ch;
    case (scan_mode)
      `SCAN_UP_FROM_ZERO: begin
        plan_first = 4'h0;
        plan_last  = top_ch;
      end
      `SCAN_REPEAT_EIGHT: begin
        plan_first = cs_eff;
        plan_last  = cs_eff;
        plan_reps  = `REPEAT_COUNT;
      end
      `SCAN_UPPER_PART: begin
        plan_first = UPPER_START;
        plan_last  = (top_ch < UPPER_START) ? UPPER_START : top_ch;
      end
      default: begin
        plan_first = cs_eff;
        plan_last  = cs_eff;
      end
    endcase
  end

  // scan engine
  reg  [1:0] scan_state;
  reg  [3:0] ch_reg, last_reg, step_reg, reps_reg;
  reg  [3:0] wr_ptr_reg, stored_reg;
  reg  [9:0] timer_reg;
  reg        scan_go;
  reg        settle_reg;
  wire       mem_we = (scan_state == S_CONV) && (conv_done_i || timer_reg == CONV_LIMIT);
  reg  [3:0] rd_ptr_reg;
  wire [9:0] rd_data;

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scan_state   <= S_IDLE;
      ch_reg       <= 4'h0;
      last_reg     <= 4'h0;
      step_reg     <= 4'h1;
      reps_reg     <= 4'h1;
      wr_ptr_reg   <= 4'h0;
      stored_reg   <= 4'h0;
      timer_reg    <= 10'h000;
      settle_reg   <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      settle_reg   <= mem_we;
      conv_start_o <= 1'b0;
      case (scan_state)
        S_IDLE: begin
          if (scan_go) begin
            ch_reg     <= plan_first;
            last_reg   <= plan_last;
            step_reg   <= plan_step;
            reps_reg   <= plan_reps;
            wr_ptr_reg <= 4'h0;
            stored_reg <= 4'h0;
            scan_state <= S_REQ;
          end
        end
        S_REQ: begin
          conv_start_o <= 1'b1;
          timer_reg    <= 10'h000;
          scan_state   <= S_CONV;
        end
        default: begin
          timer_reg <= timer_reg + 10'h001;
          if (mem_we) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH_LAST) ? 4'h0 : wr_ptr_reg + 4'h1;
            if (stored_reg != NUM_INPUTS)
              stored_reg <= stored_reg + 4'h1;
            if (reps_reg != 4'h1) begin
              reps_reg   <= reps_reg - 4'h1;
              scan_state <= S_REQ;
            end else if (ch_reg >= last_reg) begin
              scan_state <= S_IDLE;
            end else begin
              ch_reg     <= ch_reg + step_reg;
              scan_state <= S_REQ;
            end
          end
        end
      endcase
    end
  end

  // input selection for the channel being converted
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_pos_o          <= 4'h0;
      conv_neg_o          <= 4'h0;
      conv_pos_gnd_o      <= 1'b0;
      conv_neg_gnd_o      <= 1'b1;
      conv_chan_invalid_o <= 1'b0;
    end else begin
      conv_pos_o          <= ch_reg;
      conv_chan_invalid_o <= (ch_reg > `HIGHEST_CODE);
      if (sgl_sel) begin
        conv_neg_o     <= 4'h0;
        conv_pos_gnd_o <= 1'b0;
        conv_neg_gnd_o <= 1'b1;
      end else begin
        conv_neg_o     <= {ch_reg[3:1], ~ch_reg[0]};
        conv_pos_gnd_o <= ref_mode && (ch_reg == REF_CH);
        conv_neg_gnd_o <= ref_mode && ({ch_reg[3:1], ~ch_reg[0]} == REF_CH);
      end
    end
  end

  result_mem #(
    .WIDTH(10),
    .DEPTH(NUM_INPUTS),
    .AW   (4)
  ) u_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i  (mem_we),
    .wr_addr_i(wr_ptr_reg),
    .wr_data_i(conv_data_i),
    .rd_addr_i(rd_ptr_reg),
    .rd_data_o(rd_data)
  );

  // i2c link
  reg  [2:0] link_state;
  reg  [7:0] sh_reg;
  reg  [3:0] bit_cnt;
  reg        match_reg;
  reg        sda_low_reg;
  reg        stretch_reg;
  reg        load_pend_reg;
  reg        byte_sel_reg;
  // settle cycle lets the registered read see the last write
  wire       scan_busy = (scan_state != S_IDLE) | scan_go | settle_reg;
  wire [7:0] next_byte = byte_sel_reg ? rd_data[7:0] : {6'h3f, rd_data[9:8]};

  assign scl_o    = 1'b0;
  assign scl_oe_o = stretch_reg;
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_low_reg;

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_state    <= L_IDLE;
      sh_reg        <= 8'h00;
      bit_cnt       <= 4'h0;
      match_reg     <= 1'b0;
      sda_low_reg   <= 1'b0;
      stretch_reg   <= 1'b0;
      load_pend_reg <= 1'b0;
      byte_sel_reg  <= 1'b0;
      rd_ptr_reg    <= 4'h0;
      track_o       <= 1'b0;
      scan_go       <= 1'b0;
    end else begin
      scan_go <= 1'b0;
      if (load_pend_reg && !scan_busy) begin
        sh_reg        <= next_byte;
        sda_low_reg   <= ~next_byte[7];
        load_pend_reg <= 1'b0;
        stretch_reg   <= 1'b0;
      end
      if (stop_c) begin
        link_state  <= L_IDLE;
        sda_low_reg <= 1'b0;
      end else if (start_c) begin
        link_state  <= L_ADDR;
        bit_cnt     <= 4'h0;
        sda_low_reg <= 1'b0;
      end else begin
        case (link_state)
          L_ADDR: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                match_reg <= (sh_reg[6:0] == SLAVE_ADDR) && sda_s2;
                if (sh_reg[6:0] == SLAVE_ADDR && sda_s2 && !clk_ext)
                  track_o <= 1'b1;
              end
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (match_reg) begin
                sda_low_reg <= 1'b1;
                link_state  <= L_ACK;
              end else begin
                link_state  <= L_WAIT;
              end
            end
          end
          L_ACK: begin
            if (scl_fall) begin
              track_o      <= 1'b0;
              scan_go      <= 1'b1;
              rd_ptr_reg   <= 4'h0;
              byte_sel_reg <= 1'b0;
              bit_cnt      <= 4'h0;
              link_state   <= L_TX;
              if (!clk_ext) begin
                stretch_reg   <= 1'b1;
                load_pend_reg <= 1'b1;
                sda_low_reg   <= 1'b0;
              end else begin
                sh_reg      <= {6'h3f, rd_data[9:8]};
                sda_low_reg <= 1'b0;
              end
            end
          end
          L_TX: begin
            if (scl_fall && !load_pend_reg) begin
              if (bit_cnt == 4'h7) begin
                sda_low_reg <= 1'b0;
                link_state  <= L_MACK;
              end else begin
                sh_reg      <= {sh_reg[6:0], 1'b1};
                sda_low_reg <= ~sh_reg[6];
                bit_cnt     <= bit_cnt + 4'h1;
              end
            end
          end
          L_MACK: begin
            if (scl_rise) begin
              if (sda_s2) begin
                link_state <= L_WAIT;
              end else begin
                byte_sel_reg <= ~byte_sel_reg;
                if (byte_sel_reg) begin
                  if (rd_ptr_reg + 4'h1 >= stored_reg || rd_ptr_reg == DEPTH_LAST)
                    rd_ptr_reg <= 4'h0;
                  else
                    rd_ptr_reg <= rd_ptr_reg + 4'h1;
                end
              end
            end else if (scl_fall) begin
              sh_reg      <= next_byte;
              sda_low_reg <= ~next_byte[7];
              bit_cnt     <= 4'h0;
              link_state  <= L_TX;
            end
          end
          default: begin
            sda_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  always @* begin
    status_word = {16'h0000, 1'b0, link_state, rd_ptr_reg, stored_reg,
                   2'b00, stretch_reg, scan_busy};
  end
endmodule // adc_i2c_readout_sequencer

/* bench/adc_seq_asserts.sv */
// assertions on the sequencer's conversion and stretch outputs
`timescale 1ns/1ps
module adc_seq_chk (
  input wire       ref_clk_i,
  input wire       sys_rst_i,
  input wire       scl_oe_o,
  input wire       sda_oe_o,
  input wire       track_o,
  input wire       conv_start_o,
  input wire [3:0] conv_pos_o,
  input wire [3:0] conv_neg_o,
  input wire       conv_pos_gnd_o,
  input wire       conv_neg_gnd_o,
  input wire       conv_chan_invalid_o,
  input wire       conv_clk_ext_o,
  input wire       conv_done_i
);
  logic [10:0] busy;
  logic [10:0] hold;
  // open conversion age, and stretch cycles since the last start
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy <= 11'h0;
      hold <= 11'h0;
    end else begin
      if (conv_start_o)
        busy <= 11'h1;
      else if (conv_done_i || busy == 11'h3b2)
        busy <= 11'h0;
      else if (busy != 11'h0)
        busy <= busy + 11'h1;
      if (conv_start_o || !scl_oe_o)
        hold <= 11'h0;
      else
        hold <= hold + 11'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_track_int; track_o |-> !conv_clk_ext_o; endproperty
  a_track_int: assert property (p_track_int)
    else $error("tracking in external clock mode");
  property p_start_after_track; $fell(track_o) && !conv_clk_ext_o |-> ##[1:4] conv_start_o;
  endproperty
  a_start_after_track: assert property (p_start_after_track)
    else $error("no conversion start after tracking");
  property p_stretch_entry; $rose(scl_oe_o) |-> !sda_oe_o && !track_o && !conv_clk_ext_o;
  endproperty
  a_stretch_entry: assert property (p_stretch_entry)
    else $error("bad stretch entry");
  property p_start_in_stretch; conv_start_o && !conv_clk_ext_o |-> scl_oe_o; endproperty
  a_start_in_stretch: assert property (p_start_in_stretch)
    else $error("conversion without stretch");
  property p_release; $fell(scl_oe_o) |-> busy == 11'h0; endproperty
  a_release: assert property (p_release)
    else $error("clock released during conversion");
  property p_hold_bound; scl_oe_o |-> hold < 11'h3b7; endproperty
  a_hold_bound: assert property (p_hold_bound)
    else $error("stretch too long");
  property p_one_at_a_time; conv_start_o |-> busy == 11'h0; endproperty
  a_one_at_a_time: assert property (p_one_at_a_time)
    else $error("overlapping conversions");
  property p_pair; conv_start_o && !conv_pos_gnd_o && !conv_neg_gnd_o && !conv_chan_invalid_o
    |-> (conv_pos_o ^ conv_neg_o) == 4'h1; endproperty
  a_pair: assert property (p_pair)
    else $error("pair not adjacent");
endmodule // adc_seq_chk

/* bench/i2c_master_model.sv */
// i2c bus master model on open-drain scl and sda
`timescale 1ns/1ps
module i2c_master_model (
  input  wire  scl_i,
  input  wire  sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  logic stuck;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    stuck = 1'b0;
  end
  // let go of scl and wait out a stretch
  task automatic rel_scl();
    scl_low_o = 1'b0;
    for (int n = 0; n < 15000 && scl_i !== 1'b1; n++)
      #8;
    if (scl_i !== 1'b1)
      stuck = 1'b1;
  endtask
  task automatic put_bit(input logic b);
    sda_low_o = !b;
    #40;
    rel_scl();
    #80;
    scl_low_o = 1'b1;
    #40;
  endtask
  task automatic get_bit(output logic b);
    sda_low_o = 1'b0;
    #40;
    rel_scl();
    #40;
    b = sda_i;
    #40;
    scl_low_o = 1'b1;
    #40;
  endtask
  task start_cond();
    sda_low_o = 1'b1;
    #80;
    scl_low_o = 1'b1;
    #40;
  endtask
  task stop_cond();
    sda_low_o = 1'b1;
    #40;
    rel_scl();
    #80;
    sda_low_o = 1'b0;
    #80;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(r);
    ack = !r;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(!ack);
  endtask
endmodule // i2c_master_model

/* bench/adc_i2c_readout_sequencer_test.sv */
// self-checking bench for the readout sequencer
`timescale 1ns/1ps
module adc_i2c_readout_sequencer_test;
  localparam [6:0] DEV = 7'h2a; // arbitrary value
  logic        ref_clk_i;
  logic        sys_rst_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire         scl_v;
  wire         sda_v;
  wire         scl_oe;
  wire         sda_oe;
  wire         m_scl;
  wire         m_sda;
  wire         scl = !((scl_oe & !scl_v) | m_scl);
  wire         sda = !((sda_oe & !sda_v) | m_sda);
  wire         start;
  wire  [3:0]  pos;
  wire  [3:0]  neg;
  wire         pgnd;
  wire         ngnd;
  wire         bad;
  wire         ext;
  logic        done;
  logic [9:0]  data;
  logic [7:0]  expch[$];
  logic [9:0]  res[$];
  logic        mute;
  logic [31:0] rd;
  logic [7:0]  c;
  logic        ack;
  int          n_mismatch;
  int          num_checks;

  adc_i2c_readout_sequencer #(.SLAVE_ADDR(DEV)) adc_i2c_readout_sequencer_i (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .scl_i(scl), .scl_o(scl_v), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_v),
    .sda_oe_o(sda_oe),
    .track_o(), .conv_start_o(start), .conv_pos_o(pos), .conv_neg_o(neg),
    .conv_pos_gnd_o(pgnd), .conv_neg_gnd_o(ngnd), .conv_chan_invalid_o(bad),
    .conv_clk_ext_o(ext), .conv_done_i(done), .conv_data_i(data));
  i2c_master_model m_i (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = !ref_clk_i;
  end

  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_dat(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge ref_clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  function automatic logic [7:0] pair_of(input logic [3:0] p, input logic sgl, input logic rp);
    logic [3:0] q;
    q = sgl ? 4'hf : p ^ 4'h1;
    if (p > 4'hb)
      return 8'hcc;
    if (rp && q == 4'hb)
      q = 4'hf;
    if (rp && p == 4'hb)
      p = 4'hf;
    return {p, q};
  endfunction
  task plan(input logic [7:0] k, input logic rp);
    int top;
    expch = {};
    top = k[4:1];
    if (k[0] && top > 10 + !rp)
      top = 10 + !rp;
    if (!k[5])
      for (int i = k[6] ? 6 : 0; i <= (k[6] && top < 6 ? 6 : top); i += k[0] ? 1 : 2)
        expch.push_back(pair_of(i, k[0], rp));
    else
      repeat (k[6:5] == 2'h1 ? 8 : 1)
        expch.push_back(pair_of(k[4:1], k[0], rp));
  endtask
  // converter stand-in: while a plan is queued, checks each requested input and returns data
  initial forever begin
    @(posedge ref_clk_i);
    if (start === 1'b1 && expch.size() > 0) begin
      chk_dat(bad ? 8'hcc : {pgnd ? 4'hf : pos, ngnd ? 4'hf : neg}, expch.pop_front());
      data <= $urandom;
      #1 res.push_back(data);
      if (!mute) begin
        repeat ($urandom_range(1, 30)) @(posedge ref_clk_i);
        done <= 1'b1;
        @(posedge ref_clk_i);
        done <= 1'b0;
      end
    end
  end
  task round(input logic [7:0] k, input logic rp, input logic mt);
    logic [7:0] b1;
    logic [7:0] b2;
    int n;
    ahb(1'b1, 32'h0, {24'h0, k});
    ahb(1'b1, 32'h4, {26'h0, rp, 5'h0});
    plan(k, rp);
    n = expch.size();
    res = {};
    mute = mt;
    m_i.start_cond();
    m_i.wr_byte({DEV, 1'b1}, ack);
    chk_reg(ack, 1'b1);
    for (int j = 0; j <= n; j++) begin
      m_i.rd_byte(b1, 1'b1);
      m_i.rd_byte(b2, j < n);
      chk_dat({b1, b2}, {6'h3f, res[j % n]});
    end
    chk_reg(sda_oe, 1'b0);
    m_i.stop_cond();
    chk_reg(expch.size(), 0);
    chk_reg(m_i.stuck, 1'b0);
  endtask

  initial begin
    sys_rst_i = 1'b1;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    {done, data, mute, n_mismatch, num_checks} = '0;
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    void'($urandom(32'h6fa8));
    ahb(1'b0, 32'h0, 32'h0);
    chk_reg(rd, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    chk_reg(rd, 32'h0);
    chk_reg({hresp, ext}, 2'h0);
    ahb(1'b0, 32'hc, 32'h0);
    chk_reg(rd, 32'h0);
    round(8'h17, 1'b0, 1'b0);
    round(8'h17, 1'b1, 1'b0);
    round(8'h16, 1'b1, 1'b0);
    round(8'h26, 1'b0, 1'b0);
    round(8'h78, 1'b0, 1'b0);
    round(8'h61, 1'b0, 1'b1);
    repeat (8) begin
      c = $urandom;
      c[4:1] = $urandom_range(0, c[0] ? 10 : 11);
      round({1'b0, c[6:0]}, $urandom, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      m_i.start_cond();
      m_i.wr_byte(i ? {DEV, 1'b0} : {DEV ^ 7'h1, 1'b1}, ack);
      chk_reg(ack, 1'b0);
      m_i.stop_cond();
    end
    expch = {};
    ahb(1'b1, 32'h4, 32'h8);
    @(negedge ref_clk_i);
    chk_reg(ext, 1'b1);
    m_i.start_cond();
    m_i.wr_byte({DEV, 1'b1}, ack);
    m_i.rd_byte(c, 1'b0);
    m_i.stop_cond();
    chk_reg({ack, m_i.stuck}, 2'h2);
    chk_dat(c[7:2], 6'h3f);
    close_out();
  end
endmodule // adc_i2c_readout_sequencer_test

bind adc_i2c_readout_sequencer adc_seq_chk adc_seq_chk_i (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
  .track_o(track_o), .conv_start_o(conv_start_o), .conv_pos_o(conv_pos_o),
  .conv_neg_o(conv_neg_o), .conv_pos_gnd_o(conv_pos_gnd_o), .conv_neg_gnd_o(conv_neg_gnd_o),
  .conv_chan_invalid_o(conv_chan_invalid_o), .conv_clk_ext_o(conv_clk_ext_o),
  .conv_done_i(conv_done_i));
